// ### hw/host_interrupt_aggregator.sv
// Purpose: collects ten event sources into eight-bit enable, flag and mask
//          registers reached over AXI4-Lite, and drives one host interrupt
// Assumes: single clock aclk at 125 MHz, synchronous active-low reset
// Notes:   only byte lane 0 carries register data; upper bits read zero
`timescale 1ns/1ps
module host_interrupt_aggregator
  import host_irq_pkg::*;
(
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // write address channel
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  // write data channel
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // write response channel
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // read address channel
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  // read data channel
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  // event sources
  input  wire event_sources_t       sources,
  // host interrupt, active high level
  output logic                      host_irq
);

  agg_state_t             state_reg;
  agg_state_t             state_next;
  logic [NUM_SOURCES-1:0] events;
  logic                   aw_take;
  logic                   w_take;
  logic                   ar_take;
  logic                   wr_fire;
  logic [7:0]             flag_clear;
  logic [7:0]             flag_set;
  logic [7:0]             read_value;
  logic                   read_hit;
  logic                   write_hit;

  // edge detection and grouping of the raw sources
  source_conditioner u_cond (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sources (sources),
    .events  (events)
  );

  // address decode, used for both read and write paths
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a == reg_byte_addr(IDX_INTERRUPT_ENABLE)) ||
                  (a == reg_byte_addr(IDX_INTERRUPT_EVENT_FLAGS)) ||
                  (a == reg_byte_addr(IDX_INTERRUPT_FLAG_MASK));
  endfunction

  // handshake readies; a channel is refused while its slot is full or a
  // response is still outstanding, which keeps one write in flight
  assign s_axi_awready = !state_reg.aw_held && (state_reg.wr_state == WR_IDLE);
  assign s_axi_wready  = !state_reg.w_held && (state_reg.wr_state == WR_IDLE);
  assign s_axi_arready = (state_reg.rd_state == RD_IDLE);
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  // the write executes the cycle after both address and data are held
  assign wr_fire   = state_reg.aw_held && state_reg.w_held &&
                     (state_reg.wr_state == WR_IDLE);
  assign write_hit = addr_mapped(state_reg.awaddr);
  assign read_hit  = addr_mapped(s_axi_araddr);

  // one-to-clear mask for the flag register; zeros pass through
  always_comb begin
    flag_clear = 8'h00;
    if (wr_fire && state_reg.wstrb0 &&
        (state_reg.awaddr == reg_byte_addr(IDX_INTERRUPT_EVENT_FLAGS))) begin
      flag_clear = state_reg.wdata;
    end
  end

  // only enabled sources latch an event; disabled ones are dropped
  assign flag_set = events & state_reg.interrupt_enable;

  // read mux; unmapped addresses return zero with a decode error
  always_comb begin
    read_value = 8'h00;
    if (s_axi_araddr == reg_byte_addr(IDX_INTERRUPT_ENABLE)) begin
      read_value = state_reg.interrupt_enable;
    end else if (s_axi_araddr ==
                 reg_byte_addr(IDX_INTERRUPT_EVENT_FLAGS)) begin
      read_value = state_reg.interrupt_event_flags;
    end else if (s_axi_araddr == reg_byte_addr(IDX_INTERRUPT_FLAG_MASK)) begin
      read_value = state_reg.interrupt_flag_mask;
    end
  end

  // next-state logic for registers, bus slots and interrupt
  always_comb begin
    state_next = state_reg;

    // write address and data slots, taken in either order
    if (aw_take) begin
      state_next.aw_held = 1'b1;
      state_next.awaddr  = s_axi_awaddr;
    end
    if (w_take) begin
      state_next.w_held = 1'b1;
      state_next.wdata  = s_axi_wdata[7:0];
      state_next.wstrb0 = s_axi_wstrb[0];
    end

    // write path state machine
    unique case (state_reg.wr_state)
      WR_IDLE: begin
        if (wr_fire) begin
          state_next.aw_held  = 1'b0;
          state_next.w_held   = 1'b0;
          state_next.bresp    = write_hit ? RESP_OKAY : RESP_DECERR;
          state_next.wr_state = WR_RESP;
          if (state_reg.wstrb0 && (state_reg.awaddr ==
              reg_byte_addr(IDX_INTERRUPT_ENABLE))) begin
            // one enables, zero disables each source
            state_next.interrupt_enable = state_reg.wdata;
          end
          if (state_reg.wstrb0 && (state_reg.awaddr ==
              reg_byte_addr(IDX_INTERRUPT_FLAG_MASK))) begin
            state_next.interrupt_flag_mask = state_reg.wdata;
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          state_next.wr_state = WR_IDLE;
        end
      end
      default: begin
        state_next.wr_state = WR_IDLE;
      end
    endcase

    // read path state machine; data is captured at the address handshake
    unique case (state_reg.rd_state)
      RD_IDLE: begin
        if (ar_take) begin
          state_next.rdata    = read_value;
          state_next.rresp    = read_hit ? RESP_OKAY : RESP_DECERR;
          state_next.rd_state = RD_DATA;
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          state_next.rd_state = RD_IDLE;
        end
      end
      default: begin
        state_next.rd_state = RD_IDLE;
      end
    endcase

    // sticky flags: clear first, then set, so a new event wins
    // the pin and shared completion bits follow the same path
    state_next.interrupt_event_flags =
      (state_reg.interrupt_event_flags & ~flag_clear) | flag_set;

    // level interrupt from enabled, unmasked pending flags
    state_next.irq = |(state_next.interrupt_event_flags &
                       state_next.interrupt_enable &
                       ~state_next.interrupt_flag_mask);
  end

  // state register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg                       <= '0;
      state_reg.interrupt_enable      <= RST_INTERRUPT_ENABLE;
      state_reg.interrupt_event_flags <= RST_INTERRUPT_EVENT_FLAGS;
      state_reg.interrupt_flag_mask   <= RST_INTERRUPT_FLAG_MASK;
      state_reg.wr_state              <= WR_IDLE;
      state_reg.rd_state              <= RD_IDLE;
      state_reg.bresp                 <= RESP_OKAY;
      state_reg.rresp                 <= RESP_OKAY;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs; data and responses come straight from flip-flops
  assign s_axi_bvalid = (state_reg.wr_state == WR_RESP);
  assign s_axi_bresp  = state_reg.bresp;
  assign s_axi_rvalid = (state_reg.rd_state == RD_DATA);
  assign s_axi_rdata  = {24'h000000, state_reg.rdata};
  assign s_axi_rresp  = state_reg.rresp;
  assign host_irq     = state_reg.irq;

endmodule // host_interrupt_aggregator

// ### hw/host_irq_pkg.sv
// Purpose: shared constants and types for the host interrupt aggregator
// Assumes: AXI4-Lite register access with 32-bit data, one word per register
// Notes:   register indices are kept as printed; byte address is index * 4
package host_irq_pkg;

  // register indices and their byte addresses
  localparam logic [7:0]  IDX_INTERRUPT_ENABLE      = 8'h0B;
  localparam logic [7:0]  IDX_INTERRUPT_EVENT_FLAGS = 8'h0C;
  localparam logic [7:0]  IDX_INTERRUPT_FLAG_MASK   = 8'h0D;
  localparam int          ADDR_W                    = 12;

  // reset values
  localparam logic [7:0]  RST_INTERRUPT_ENABLE      = 8'h00;
  localparam logic [7:0]  RST_INTERRUPT_EVENT_FLAGS = 8'h00;
  localparam logic [7:0]  RST_INTERRUPT_FLAG_MASK   = 8'h00;

  // bit positions, shared by enable, flag and mask registers
  localparam int          BIT_WAKEUP                = 7;
  localparam int          BIT_EXT_PIN               = 6;
  localparam int          BIT_I2C_MASTER            = 5;
  localparam int          BIT_VSYNC                 = 4;
  localparam int          BIT_KEYPAD                = 3;
  localparam int          BIT_PROCESS_DONE          = 2;
  localparam int          BIT_PWM1                  = 1;
  localparam int          BIT_PWM0                  = 0;
  localparam int          NUM_SOURCES               = 8;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY                 = 2'h0;
  localparam logic [1:0]  RESP_DECERR               = 2'h3;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_byte_addr(input logic [7:0] idx);
    reg_byte_addr = {{(ADDR_W-10){1'b0}}, idx, 2'h0};
  endfunction

  // event inputs from the internal sources
  typedef struct packed {
    logic wakeup;          // pulse: wakeup/resume
    logic external_interrupt_pin; // level: external pin, rising edge counts
    logic i2c_master;      // pulse
    logic vsync;           // level: vertical sync, rising edge counts
    logic keypad;          // pulse
    logic flash_dma_done;  // pulse
    logic draw_done;       // pulse
    logic block_transfer_engine_done; // pulse
    logic pwm1;            // pulse
    logic pwm0;            // pulse
  } event_sources_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_DATA = 2'h2
  } rd_state_t;

  // conditioner state
  typedef struct packed {
    logic                   vsync_prev;
    logic                   pin_prev;
    logic [NUM_SOURCES-1:0] events;
  } cond_state_t;

  // aggregator state
  typedef struct packed {
    logic [7:0]        interrupt_enable;
    logic [7:0]        interrupt_event_flags;
    logic [7:0]        interrupt_flag_mask;
    wr_state_t         wr_state;
    rd_state_t         rd_state;
    logic              aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic              w_held;
    logic [7:0]        wdata;
    logic              wstrb0;
    logic [1:0]        bresp;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic              irq;
  } agg_state_t;

endpackage

// ### hw/source_conditioner.sv
// Purpose: turns raw source signals into one-cycle event pulses
// Assumes: all inputs synchronous to aclk
// Notes:   events are registered, so they reach the flags one cycle late
`timescale 1ns/1ps
module source_conditioner
  import host_irq_pkg::*;
(
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // raw sources
  input  wire event_sources_t         sources,
  // one event pulse per flag bit, the three completions sharing one, flag bit layout
  output logic [NUM_SOURCES-1:0]      events
);

  cond_state_t state_reg;
  cond_state_t state_next;

  // edge detection and merging of the process-complete group
  always_comb begin
    state_next            = state_reg;
    state_next.vsync_prev = sources.vsync;
    state_next.pin_prev   = sources.external_interrupt_pin;
    state_next.events     = '0;
    state_next.events[BIT_WAKEUP]     = sources.wakeup;
    // a level pin must not refire every cycle while it stays high
    state_next.events[BIT_EXT_PIN]    = sources.external_interrupt_pin &
                                        ~state_reg.pin_prev;
    state_next.events[BIT_I2C_MASTER] = sources.i2c_master;
    // one event per frame, on the rising edge of vsync
    state_next.events[BIT_VSYNC]      = sources.vsync &
                                        ~state_reg.vsync_prev;
    state_next.events[BIT_KEYPAD]     = sources.keypad;
    // any of the three completions lands on one shared bit
    state_next.events[BIT_PROCESS_DONE] = sources.flash_dma_done |
                                          sources.draw_done |
                                          sources.block_transfer_engine_done;
    state_next.events[BIT_PWM1]       = sources.pwm1;
    state_next.events[BIT_PWM0]       = sources.pwm0;
  end

  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign events = state_reg.events;

endmodule // source_conditioner

// ### dv/host_irq_props.sv
// Purpose: port checks for the host interrupt aggregator
// Assumes: one clock, synchronous active-low reset
// Notes:   sees top ports only; bound after the module
`timescale 1ns/1ps
module host_irq_props
  import host_irq_pkg::*;
(
  // clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // register bus
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  // events and interrupt
  input wire event_sources_t   sources,
  input wire logic             host_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_r_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  a_dec_read: assert property (s_axi_arvalid && s_axi_arready &&
    !(s_axi_araddr inside {12'h02C, 12'h030, 12'h034}) |=>
    s_axi_rresp == RESP_DECERR) else $error("no decode error");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  a_aw_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("ready in response");
  // an interrupt only starts from an event or a register write
  a_irq_cause: assert property ($rose(host_irq) |->
    $rose(s_axi_bvalid) || $past(|sources, 2)) else $error("stray irq");
  a_irq_drop: assert property ($fell(host_irq) |->
    $rose(s_axi_bvalid)) else $error("irq fell alone");
endmodule // host_irq_props

bind host_interrupt_aggregator host_irq_props props_i (.*);

// ### dv/host_model.sv
// Purpose: host side, an AXI4-Lite master for register access
// Assumes: tasks are entered just after a rising edge
// Notes:   each payload is held until its own ready is sampled
`timescale 1ns/1ps
module host_model
  import host_irq_pkg::*;
(
  // clock
  input wire logic              aclk,
  // write channels
  output logic                  s_axi_awvalid,
  input wire logic              s_axi_awready,
  output logic [ADDR_W-1:0]     s_axi_awaddr,
  output logic [2:0]            s_axi_awprot,
  output logic                  s_axi_wvalid,
  input wire logic              s_axi_wready,
  output logic [31:0]           s_axi_wdata,
  output logic [3:0]            s_axi_wstrb,
  input wire logic              s_axi_bvalid,
  output logic                  s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  // read channels
  output logic                  s_axi_arvalid,
  input wire logic              s_axi_arready,
  output logic [ADDR_W-1:0]     s_axi_araddr,
  output logic [2:0]            s_axi_arprot,
  input wire logic              s_axi_rvalid,
  output logic                  s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp
);
  // idle bus from time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 8'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
  end

  // a set flag is serviced by writing a one to its bit
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v,
                    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // masked sources are found by polling the flags
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule // host_model

// ### dv/host_interrupt_aggregator_tb.sv
// Purpose: self-checking bench for the host interrupt aggregator
// Assumes: host_model drives the register bus
// Notes:   random enables, masks, events and clears, seed fixed
`timescale 1ns/1ps
module host_interrupt_aggregator_tb
  import host_irq_pkg::*;
;
  localparam logic [ADDR_W-1:0] A_EN = 12'h02C;
  localparam logic [ADDR_W-1:0] A_FL = 12'h030;
  localparam logic [ADDR_W-1:0] A_MK = 12'h034;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, host_irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]        s_axi_awprot, s_axi_arprot;
  logic [31:0]       s_axi_wdata, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic [7:0]        en, mk, f, c;
  event_sources_t    sources = '0;
  event_sources_t    s;
  int                n_fail = 0;
  int                tests_run = 0;
  int                seed = 97;

  host_interrupt_aggregator dut (.*);
  host_model h (.*);

  always #4 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    h.rd(a, v, rs);
    chk(v, {24'h0, e});
  endtask

  // flag bits that a source vector should set, process sources merged
  function automatic logic [7:0] fl(input event_sources_t e);
    return {e.wakeup, e.external_interrupt_pin, e.i2c_master, e.vsync,
            e.keypad, e.flash_dma_done | e.draw_done |
            e.block_transfer_engine_done, e.pwm1, e.pwm0};
  endfunction

  // one-cycle event, then time for it to reach the flags
  task automatic pulse(input event_sources_t e);
    sources <= e;
    @(posedge aclk);
    sources <= '0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // the normal run costs far less than the 20000 cycles allowed before a hang is declared
  initial begin : watchdog
    repeat (20000) @(posedge aclk);
    n_fail++;
    conclude();
  end

  initial begin : main
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // reset values, then an unmapped word
    for (int i = 11; i < 15; i++) begin
      h.rd({2'h0, 8'(i), 2'h0}, d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'(i == 14 ? RESP_DECERR : RESP_OKAY));
    end
    chk(32'(host_irq), 32'h0);
    h.wr(12'h038, 8'hFF, r);
    chk(32'(r), 32'(RESP_DECERR));
    $display("test reset and decode done");
    // random enables, masks, events and partial clears
    for (int k = 0; k < 24; k++) begin
      en = 8'($random(seed));
      mk = 8'($random(seed));
      s = 10'($random(seed));
      c = 8'($random(seed));
      h.wr(A_EN, en, r);
      h.wr(A_MK, mk, r);
      rd_chk(A_EN, en);
      rd_chk(A_MK, mk);
      pulse(s);
      f = fl(s) & en;
      rd_chk(A_FL, f);
      chk(32'(host_irq), 32'(|(f & ~mk)));
      h.wr(A_FL, c, r);
      rd_chk(A_FL, f & ~c);
      chk(32'(host_irq), 32'(|(f & ~c & ~mk)));
      h.wr(A_FL, 8'hFF, r);
      rd_chk(A_FL, 8'h00);
      // no flag left, so no cause elsewhere may keep the line up
      chk(32'(host_irq), 32'h0);
    end
    $display("test random events done");
    // each process source alone, then an event racing its own clear
    h.wr(A_MK, 8'h00, r);
    h.wr(A_EN, 8'hFF, r);
    for (int i = 2; i < 5; i++) begin
      s = '0;
      s[i] = 1'b1;
      pulse(s);
      rd_chk(A_FL, 8'h04);
      sources <= s;
      fork
        h.wr(A_FL, 8'h04, r);
        begin
          @(posedge aclk);
          sources <= '0;
        end
      join
      rd_chk(A_FL, 8'h04);
      h.wr(A_FL, 8'h04, r);
      rd_chk(A_FL, 8'h00);
    end
    $display("test shared flag done");
    // a write without lane 0 strobe stores nothing but answers okay
    h.s_axi_wstrb <= 4'hE;
    h.wr(A_EN, 8'h5A, r);
    chk(32'(r), 32'(RESP_OKAY));
    h.s_axi_wstrb <= 4'hF;
    rd_chk(A_EN, 8'hFF);
    $display("test byte strobe done");
    conclude();
  end
endmodule // host_interrupt_aggregator_tb
